/* verilog/seep_pkg.sv */
// Constants, opcodes and state types of the serial memory port
package seep_pkg;

  // Array organisation
  localparam int SEEP_WORDS = 16;
  localparam int SEEP_ADDR_W = 4;
  localparam int SEEP_DATA_W = 16;
  localparam int SEEP_OP_W = 4;

  // Instruction opcodes and the fixed address of the program enable and chip erase commands
  localparam logic [3:0] OP_READ = 4'h8;
  localparam logic [3:0] OP_WRITE = 4'h4;
  localparam logic [3:0] OP_ERASE = 4'hC;
  localparam logic [3:0] OP_PROGRAM_ENABLE_CMD = 4'h3;
  localparam logic [3:0] OP_PROGRAM_DISABLE_CMD = 4'h0;
  localparam logic [3:0] OP_CHIP_ERASE_CMD = 4'h2;
  localparam logic [3:0] ADDR_ZERO = 4'h0;

  // Frame lengths after the start bit
  localparam logic [4:0] INSTR_BITS = 5'h08;
  localparam logic [4:0] WRITE_FRAME_BITS = 5'h18;
  localparam int CMD_W = 24;

  // Read answer: dummy zero then the word
  localparam int READ_BITS = 17;
  localparam logic [4:0] READ_LAST = 5'h10;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // Command queue
  localparam int FIFO_DEPTH = 8;

  // Programming pulse window
  localparam int MCLK_HZ = 20000000;
  localparam int TEW_MIN_MS = 10;
  localparam int TEW_MAX_MS = 30;
  localparam int TEW_MIN_CYC = (TEW_MIN_MS * MCLK_HZ + 999) / 1000;
  localparam int TEW_MAX_CYC = (TEW_MAX_MS * MCLK_HZ) / 1000;
  localparam int PCNT_W = 20;

  typedef enum logic [1:0] {
    DS_HUNT = 2'b00,
    DS_SHIFT = 2'b01,
    DS_HOLD = 2'b11
  } seep_ds_e;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_READ = 2'b01,
    EX_ARM = 2'b11,
    EX_PROG = 2'b10
  } seep_ex_e;

endpackage : seep_pkg

/* verilog/seep_port.sv */
// Serial command port, command queue and programming control of a 16x16 memory

// Synchronous FIFO with valid and ready on both sides
module seep_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] wr_ptr_next;
  logic [PW:0] rd_ptr_reg;
  logic [PW:0] rd_ptr_next;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                      (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data = store_reg[rd_ptr_reg[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer advance
  always_comb begin
    wr_ptr_next = push ? (PW+1)'(1) + wr_ptr_reg : wr_ptr_reg;
    rd_ptr_next = pop ? (PW+1)'(1) + rd_ptr_reg : rd_ptr_reg;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage words carry no reset
  always_ff @(posedge mclk) begin
    if (push) begin
      store_reg[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end

endmodule : seep_fifo

// Device side of the serial port with the word array
module seep_port #(
  parameter int TEW_MIN_CYCLES = seep_pkg::TEW_MIN_CYC,
  parameter int TEW_MAX_CYCLES = seep_pkg::TEW_MAX_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  output logic prog_hv_active,
  output logic program_enabled
);
  import seep_pkg::*;

  localparam logic [PCNT_W-1:0] MIN_L = PCNT_W'(TEW_MIN_CYCLES);
  localparam logic [PCNT_W-1:0] MAX_L = PCNT_W'(TEW_MAX_CYCLES);

  // Programming opcode that also carries a legal address
  function automatic logic is_prog_op(input logic [3:0] op, input logic [3:0] addr);
    is_prog_op = (op == OP_WRITE) || (op == OP_ERASE) ||
                 ((op == OP_CHIP_ERASE_CMD) && (addr == ADDR_ZERO));
  endfunction : is_prog_op

  logic sclk_prev_reg;
  logic sclk_rise;
  seep_ds_e ds_reg;
  seep_ds_e ds_next;
  logic [4:0] ds_cnt_reg;
  logic [4:0] ds_cnt_next;
  logic [CMD_W-1:0] ds_shift_reg;
  logic [CMD_W-1:0] ds_shift_next;
  logic [CMD_W-1:0] sh_in;
  logic [4:0] cnt_inc;
  logic push_valid;
  logic [CMD_W-1:0] push_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [CMD_W-1:0] fifo_out_data;
  logic pop;
  seep_ex_e ex_reg;
  seep_ex_e ex_next;
  logic [CMD_W-1:0] cmd_reg;
  logic [CMD_W-1:0] cmd_next;
  logic [READ_BITS-1:0] out_shift_reg;
  logic [READ_BITS-1:0] out_shift_next;
  logic out_en_reg;
  logic out_en_next;
  logic [4:0] rd_cnt_reg;
  logic [4:0] rd_cnt_next;
  logic [PCNT_W-1:0] pcnt_reg;
  logic [PCNT_W-1:0] pcnt_next;
  logic prog_en_reg;
  logic prog_en_next;
  logic commit;
  logic [15:0] mem_reg [SEEP_WORDS];
  logic [15:0] mem_next [SEEP_WORDS];
  logic [3:0] pop_op;
  logic [3:0] pop_addr;
  logic [3:0] cur_op;
  logic [3:0] cur_addr;

  assign sclk_rise = serial_clock && !sclk_prev_reg;
  assign sh_in = {ds_shift_reg[CMD_W-2:0], serial_data_in};
  assign cnt_inc = ds_cnt_reg + 5'h01;
  assign pop_op = fifo_out_data[23:20];
  assign pop_addr = fifo_out_data[19:16];
  assign cur_op = cmd_reg[23:20];
  assign cur_addr = cmd_reg[19:16];

  // Deserialiser: hunt for start bit, gather frame, push to queue
  always_comb begin
    ds_next = ds_reg;
    ds_cnt_next = ds_cnt_reg;
    ds_shift_next = ds_shift_reg;
    push_valid = 1'b0;
    push_data = '0;
    if (!chip_select) begin
      ds_next = DS_HUNT;
      ds_cnt_next = '0;
    end else if (sclk_rise) begin
      unique case (ds_reg)
        DS_HUNT: begin
          // A start bit is taken only when the queue has room
          if (serial_data_in && fifo_in_ready) begin
            ds_next = DS_SHIFT;
            ds_cnt_next = '0;
          end
        end
        DS_SHIFT: begin
          ds_shift_next = sh_in;
          ds_cnt_next = cnt_inc;
          if (cnt_inc == INSTR_BITS && sh_in[7:4] != OP_WRITE) begin
            push_valid = 1'b1;
            push_data = {sh_in[7:0], 16'h0000};
            ds_next = (sh_in[7:4] == OP_READ) ? DS_HOLD : DS_HUNT;
          end else if (cnt_inc == WRITE_FRAME_BITS) begin
            push_valid = 1'b1;
            push_data = sh_in;
            ds_next = DS_HUNT;
          end
        end
        DS_HOLD: begin
          ds_next = DS_HOLD;
        end
        // Unused code falls back to hunting
        default: begin
          ds_next = DS_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      ds_reg <= DS_HUNT;
      ds_cnt_reg <= '0;
      ds_shift_reg <= '0;
    end else begin
      sclk_prev_reg <= serial_clock;
      ds_reg <= ds_next;
      ds_cnt_reg <= ds_cnt_next;
      ds_shift_reg <= ds_shift_next;
    end
  end

  // Queue between the serial front end and the executor
  seep_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // Executor: reads, mode commands and programming pulses
  always_comb begin
    ex_next = ex_reg;
    cmd_next = cmd_reg;
    out_shift_next = out_shift_reg;
    out_en_next = out_en_reg;
    rd_cnt_next = rd_cnt_reg;
    pcnt_next = pcnt_reg;
    prog_en_next = prog_en_reg;
    pop = 1'b0;
    commit = 1'b0;
    unique case (ex_reg)
      EX_IDLE: begin
        if (fifo_out_valid) begin
          pop = 1'b1;
          cmd_next = fifo_out_data;
          if (pop_op == OP_READ) begin
            // Served regardless of the enable state
            out_shift_next = {1'b0, mem_reg[pop_addr]};
            out_en_next = 1'b1;
            rd_cnt_next = '0;
            ex_next = EX_READ;
          end else if (pop_op == OP_PROGRAM_ENABLE_CMD && pop_addr == ADDR_ZERO) begin
            prog_en_next = 1'b1;
          end else if (pop_op == OP_PROGRAM_DISABLE_CMD) begin
            prog_en_next = 1'b0;
          end else if (is_prog_op(pop_op, pop_addr) && prog_en_reg) begin
            ex_next = EX_ARM;
          end
        end
      end
      EX_READ: begin
        if (!chip_select) begin
          out_en_next = 1'b0;
          ex_next = EX_IDLE;
        end else if (sclk_rise) begin
          if (rd_cnt_reg == READ_LAST) begin
            out_en_next = 1'b0;
            ex_next = EX_IDLE;
          end else begin
            // Next bit shortly after the rising edge
            out_shift_next = {out_shift_reg[READ_BITS-2:0], 1'b0};
            rd_cnt_next = rd_cnt_reg + 5'h01;
          end
        end
      end
      EX_ARM: begin
        // A new instruction before select falls abandons the pulse
        if (fifo_out_valid) begin
          ex_next = EX_IDLE;
        end else if (!chip_select) begin
          pcnt_next = '0;
          ex_next = EX_PROG;
        end
      end
      EX_PROG: begin
        if (chip_select) begin
          // Pulse ends on select rise; short pulses leave data untouched
          commit = (pcnt_reg >= MIN_L);
          ex_next = EX_IDLE;
        end else if (pcnt_reg != MAX_L) begin
          pcnt_next = pcnt_reg + PCNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ex_reg <= EX_IDLE;
      cmd_reg <= '0;
      out_shift_reg <= '0;
      out_en_reg <= 1'b0;
      rd_cnt_reg <= '0;
      pcnt_reg <= '0;
      prog_en_reg <= 1'b0;
    end else begin
      ex_reg <= ex_next;
      cmd_reg <= cmd_next;
      out_shift_reg <= out_shift_next;
      out_en_reg <= out_en_next;
      rd_cnt_reg <= rd_cnt_next;
      pcnt_reg <= pcnt_next;
      prog_en_reg <= prog_en_next;
    end
  end

  // Array update on a completed programming pulse
  always_comb begin
    for (int i = 0; i < SEEP_WORDS; i++) begin
      mem_next[i] = mem_reg[i];
      if (commit) begin
        if (cur_op == OP_CHIP_ERASE_CMD) begin
          mem_next[i] = ERASED_WORD;
        end else if (cur_addr == 4'(i) && cur_op == OP_ERASE) begin
          mem_next[i] = ERASED_WORD;
        end else if (cur_addr == 4'(i) && cur_op == OP_WRITE) begin
          mem_next[i] = mem_reg[i] & cmd_reg[15:0];
        end
      end
    end
  end

  // Array cells are non-volatile: no reset
  always_ff @(posedge mclk) begin
    mem_reg <= mem_next;
  end

  // Pins
  assign serial_data_out = out_shift_reg[READ_BITS-1];
  assign serial_data_out_en = out_en_reg;
  assign prog_hv_active = (ex_reg == EX_PROG) && (pcnt_reg != MAX_L);
  assign program_enabled = prog_en_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_out_read_only: assert property (serial_data_out_en |-> ex_reg == EX_READ)
    else $error("data out driven outside a read");
  a_dummy_zero: assert property ($rose(serial_data_out_en) |-> !serial_data_out)
    else $error("read did not open with a zero");
  a_out_change_high: assert property (
    serial_data_out_en && $past(serial_data_out_en) && $changed(serial_data_out)
      |-> serial_clock)
    else $error("data out changed while serial clock low");
  a_hv_prog_only: assert property (
    prog_hv_active |-> ex_reg == EX_PROG && prog_en_reg && !$past(chip_select))
    else $error("high voltage outside a programming pulse");
  a_hv_stop_rise: assert property (
    prog_hv_active && chip_select |=> !prog_hv_active && ex_reg == EX_IDLE)
    else $error("programming not ended by select rise");
  a_powerup_locked: assert property (disable iff (1'b0) $fell(rst) |-> !program_enabled)
    else $error("programming enabled after reset");
  a_arm_needs_en: assert property (
    ex_reg == EX_IDLE && ex_next == EX_ARM |-> prog_en_reg && is_prog_op(pop_op, pop_addr))
    else $error("programming armed while disabled");
  a_erase_word: assert property (
    commit && cur_op == OP_ERASE |=> mem_reg[$past(cur_addr)] == ERASED_WORD)
    else $error("word erase did not set ones");
  a_chip_erase: assert property (
    commit && cur_op == OP_CHIP_ERASE_CMD |=> mem_reg[0] == ERASED_WORD &&
      mem_reg[SEEP_WORDS-1] == ERASED_WORD)
    else $error("chip erase did not set ones");
  a_write_clears: assert property (
    commit && cur_op == OP_WRITE |=> (mem_reg[$past(cur_addr)] & ~$past(cmd_reg[15:0])) == 16'h0000)
    else $error("write left a zero data bit set");
  a_select_abort: assert property (!chip_select |=> ds_reg == DS_HUNT)
    else $error("partial frame kept after select fell");
  a_read_length: assert property (
    $fell(serial_data_out_en) && chip_select |-> $past(rd_cnt_reg) == READ_LAST)
    else $error("read ended before seventeen bits");

endmodule : seep_port

/* test/seep_host.sv */
// Host microcontroller model driving the serial command port
module seep_host (
  input wire logic mclk,
  output logic chip_select,
  output logic serial_clock,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  input wire logic prog_hv_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_seen;
  logic hv_seen;
  logic hv_end;
  logic moved;
  logic rd_last;
  logic clash;
  logic [16:0] rd_bits;

  // Idle levels: select low, clock standing still
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end

  // Wait whole clocks, landing just past each edge and watching outputs
  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      #5;
      en_seen = en_seen | serial_data_out_en;
      hv_seen = hv_seen | prog_hv_active;
    end
  endtask : step

  // One serial clock period; output sampled late in the high phase
  task automatic pulse(input logic b, output logic s);
    serial_data_in = b;
    step(4);
    if (serial_data_out_en && serial_data_out !== rd_last) moved = 1'b1;
    serial_clock = 1'b1;
    step(4);
    // Released line reads as the inverse of the last driven level
    s = serial_data_out_en ? serial_data_out : ~serial_data_out;
    rd_last = serial_data_out;
    serial_clock = 1'b0;
  endtask : pulse

  // Whole instruction, read-out when asked, then the programming hold
  task automatic xfer(input logic [3:0] op, input logic [3:0] addr,
                      input logic [15:0] data, input int low);
    logic s;
    logic [24:0] f;
    int n;
    f = {1'b1, op, addr, data};
    n = (op == 4'h4) ? 25 : 9;
    en_seen = 1'b0;
    hv_seen = 1'b0;
    moved = 1'b0;
    chip_select = 1'b1;
    for (int i = 24; i > 24 - n; i--) pulse(f[i], s);
    rd_bits[16] = s;
    // Tied lines would fight when A0 still stands against the dummy zero
    clash = (s !== f[16]);
    if (op == 4'h8) begin
      for (int k = 15; k >= 0; k--) pulse(1'b0, rd_bits[k]);
      pulse(1'b0, s);
    end
    // Release the data line and hold select low for the pulse
    chip_select = 1'b0;
    serial_data_in = ~serial_data_in;
    step(low);
    hv_end = prog_hv_active;
    chip_select = 1'b1;
    step(8);
  endtask : xfer

  // Partial frame abandoned by dropping select
  task automatic abort_frame;
    logic s;
    chip_select = 1'b1;
    pulse(1'b1, s);
    pulse(1'b1, s);
    pulse(1'b1, s);
    chip_select = 1'b0;
    serial_data_in = ~serial_data_in;
    step(8);
  endtask : abort_frame
endmodule : seep_host

/* test/seep_port_tb.sv */
// Self-checking bench for the serial memory port
module seep_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import seep_pkg::*;
  typedef struct {
    logic [3:0] op;
    logic [3:0] addr;
    logic [15:0] data;
    int low;
    logic pe;
    logic hv;
  } seep_row_s;
  logic mclk;
  logic rst;
  logic chip_select;
  logic serial_clock;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_en;
  logic prog_hv_active;
  logic program_enabled;
  int fail_count;
  int compares;
  seep_row_s rows [14];

  seep_port #(.TEW_MIN_CYCLES(20), .TEW_MAX_CYCLES(60)) seep_port_i (
    .mclk(mclk), .rst(rst), .chip_select(chip_select), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en), .prog_hv_active(prog_hv_active),
    .program_enabled(program_enabled));

  seep_host seep_host_i (
    .mclk(mclk), .chip_select(chip_select), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en), .prog_hv_active(prog_hv_active));

  // Clock at 20 MHz
  always #25 mclk = ~mclk;

  // Compare one flag
  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // Compare one word
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  // Print counts and verdict, then stop
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // Full read with expected word
  task automatic read_check(input logic [3:0] a, input logic [15:0] exp);
    seep_host_i.xfer(OP_READ, a, 16'h0000, 4);
    check_word("read word", exp, seep_host_i.rd_bits[15:0]);
  endtask : read_check

  // Watchdog, far beyond the expected run of some 3700 clocks
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end

  // Main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    fail_count = 0;
    compares = 0;
    // First write to each word goes to an erased word; second write only clears bits
    rows = '{
      '{OP_CHIP_ERASE_CMD, 4'h0, 16'h0000, 30, 1'b0, 1'b0},
      '{OP_PROGRAM_ENABLE_CMD, 4'h0, 16'h0000, 4, 1'b1, 1'b0},
      '{OP_CHIP_ERASE_CMD, 4'h0, 16'h0000, 30, 1'b1, 1'b1},
      '{OP_READ, 4'h5, 16'hFFFF, 4, 1'b1, 1'b0},
      '{OP_WRITE, 4'h5, 16'hA5C3, 30, 1'b1, 1'b1},
      '{OP_READ, 4'h5, 16'hA5C3, 4, 1'b1, 1'b0},
      '{OP_WRITE, 4'h5, 16'h0FF0, 30, 1'b1, 1'b1},
      '{OP_READ, 4'h5, 16'h05C0, 4, 1'b1, 1'b0},
      '{OP_ERASE, 4'h5, 16'h0000, 30, 1'b1, 1'b1},
      '{OP_READ, 4'h5, 16'hFFFF, 4, 1'b1, 1'b0},
      '{OP_WRITE, 4'hF, 16'h1234, 30, 1'b1, 1'b1},
      '{OP_PROGRAM_DISABLE_CMD, 4'h0, 16'h0000, 4, 1'b0, 1'b0},
      '{OP_ERASE, 4'hF, 16'h0000, 30, 1'b0, 1'b0},
      '{OP_READ, 4'hF, 16'h1234, 4, 1'b0, 1'b0}
    };
    repeat (10) @(posedge mclk);
    #5;
    check_bit("enable at reset", 1'b0, program_enabled);
    rst = 1'b0;
    // Ordinary cases from the table
    foreach (rows[i]) begin
      seep_host_i.xfer(rows[i].op, rows[i].addr, rows[i].data, rows[i].low);
      if (rows[i].op == OP_READ) begin
        check_word("read word", rows[i].data, seep_host_i.rd_bits[15:0]);
        check_bit("dummy zero", 1'b0, seep_host_i.rd_bits[16]);
        check_bit("out enabled", 1'b1, seep_host_i.en_seen);
        check_bit("out moved low", 1'b0, seep_host_i.moved);
        check_bit("tied line clash", rows[i].addr[0], seep_host_i.clash);
      end else begin
        check_bit("out idle", 1'b0, seep_host_i.en_seen);
        check_bit("hv seen", rows[i].hv, seep_host_i.hv_seen);
      end
      check_bit("out released", 1'b0, serial_data_out_en);
      check_bit("program enable", rows[i].pe, program_enabled);
    end
    // Pulse shorter than the minimum leaves the word alone
    seep_host_i.xfer(OP_PROGRAM_ENABLE_CMD, 4'h0, 16'h0000, 4);
    seep_host_i.xfer(OP_WRITE, 4'hF, 16'h0000, 10);
    read_check(4'hF, 16'h1234);
    // Overlong hold: voltage off at the maximum, erase still done
    seep_host_i.xfer(OP_ERASE, 4'hF, 16'h0000, 100);
    check_bit("hv after max", 1'b0, seep_host_i.hv_end);
    read_check(4'hF, 16'hFFFF);
    // Abandoned frame, then a clean read
    seep_host_i.abort_frame();
    read_check(4'hF, 16'hFFFF);
    // Second reset in mid-run
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #5;
    check_bit("enable after reset", 1'b0, program_enabled);
    check_bit("hv after reset", 1'b0, prog_hv_active);
    rst = 1'b0;
    seep_host_i.xfer(OP_ERASE, 4'h5, 16'h0000, 30);
    check_bit("hv when disabled", 1'b0, seep_host_i.hv_seen);
    summarize();
  end
endmodule : seep_port_tb
